/* logic/pft_pkg.sv */
// Constants, register map and delay tables of the protection fault timers.
// Behaviour
// RULE1 - Power-good fall waits 0-15 ms in 1 ms steps.
// RULE2 - Power-good rise waits 0-15 ms.
// RULE3 - I/V conversions start every 102.4 us.
// RULE4 - A temperature conversion starts every 200 ms.
// RULE5 - A gate still high 10 ms into a fault flags a stuck discharge.
// RULE6 - Fast discharge pulses the pull-down once for 15 us.
// RULE7 - Turn-off starts within 1 us of a trigger; in cool-down or retry a trigger returns to run and clears gate_off.
// RULE8 - The fault pin stays asserted at least 20 us.
// RULE9 - Retry cool-down is 0 to 64 s.
// RULE10 - Retry-ok must persist 0, 0.5, 1, 2, 3, 4, 6 or 8 s.
// RULE11 - The first power-down step lasts a 10-bit count of 25 ns units.
// RULE12 - Undervoltage waits a 0 to 1000 ms delay.
// RULE13 - Overvoltage waits a 0 to 1000 ms delay.
// RULE14 - Input overvoltage is seen in 2 us, then filtered 0 to 1000 us.
// RULE15 - Output undervoltage waits 0 to 1000 ms.
// RULE16 - Watchdog period is 5 to 15000 ms.
// RULE17 - Code 110 gives the longest listed delay.
package pft_pkg;
  localparam int CLK_NS      = 4;
  localparam int MS_NS       = 1000000;
  localparam int US_NS       = 1000;
  localparam int T_ADC_IV_NS = 102400;
  localparam int T_HOLD_NS   = 20000;
  localparam int T_FAST_NS   = 15000;
  localparam int STEP_NS     = 25;
  localparam int T_DISCH_MS  = 10;
  localparam int T_TEMP_MS   = 200;
  localparam int US_CYCLES   = US_NS / CLK_NS;
  localparam int FAST_CYCLES = (T_FAST_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_CFG   = 8'h04;
  localparam logic [7:0] A_STAT  = 8'h08;
  localparam logic [7:0] A_IRQ   = 8'h0c;
  localparam logic [7:0] A_MASK  = 8'h10;
  localparam logic [7:0] A_KICK  = 8'h14;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CFG_RST  = 32'h0000_0000;

  // Field positions in CTRL.
  localparam int F_RISE = 0;
  localparam int F_FALL = 4;
  localparam int F_UV   = 8;
  localparam int F_OV   = 12;
  localparam int F_OVIN = 16;
  localparam int F_OUV  = 20;
  localparam int F_COOL = 24;
  localparam int F_RTRY = 28;
  // Field positions in CFG.
  localparam int F_STEP = 0;
  localparam int F_FAST = 12;
  localparam int F_REN  = 13;
  localparam int F_WSEL = 16;
  localparam int F_WEN  = 20;
  // Pin order; low IRQ bits too.
  localparam int P_UV   = 0;
  localparam int P_OV   = 1;
  localparam int P_OVIN = 2;
  localparam int P_OUV  = 3;
  localparam int P_PG   = 4;
  localparam int P_VGS  = 5;
  localparam int P_ROK  = 6;
  localparam int E_WDOG = 4;
  localparam int E_SGD  = 5;
  localparam int NEV    = 6;

  typedef enum logic [1:0] {ST_RUN, ST_FAULT, ST_COOL, ST_RETRY} pft_state_t;

  function automatic logic [16:0] pft_fault_ms(input logic [2:0] c);
    unique case (c)
      3'h0: pft_fault_ms = 17'h0;
      3'h1: pft_fault_ms = 17'd1;
      3'h2: pft_fault_ms = 17'd5;
      3'h3: pft_fault_ms = 17'd10;
      3'h4: pft_fault_ms = 17'd50;
      3'h5: pft_fault_ms = 17'd100;
      3'h6, 3'h7: pft_fault_ms = 17'd1000; // [RULE17]
    endcase
  endfunction

  function automatic logic [16:0] pft_ovin_us(input logic [2:0] c);
    unique case (c)
      3'h0: pft_ovin_us = 17'h0;
      3'h1: pft_ovin_us = 17'd10;
      3'h2: pft_ovin_us = 17'd20;
      3'h3: pft_ovin_us = 17'd50;
      3'h4: pft_ovin_us = 17'd100;
      3'h5: pft_ovin_us = 17'd200;
      3'h6, 3'h7: pft_ovin_us = 17'd1000; // [RULE17]
    endcase
  endfunction

  function automatic logic [16:0] pft_cool_ms(input logic [2:0] c);
    unique case (c)
      3'h0: pft_cool_ms = 17'h0;
      3'h1: pft_cool_ms = 17'd1000;
      3'h2: pft_cool_ms = 17'd2000;
      3'h3: pft_cool_ms = 17'd4000;
      3'h4: pft_cool_ms = 17'd8000;
      3'h5: pft_cool_ms = 17'd16000;
      3'h6, 3'h7: pft_cool_ms = 17'd64000; // [RULE17]
    endcase
  endfunction

  function automatic logic [16:0] pft_retry_ms(input logic [2:0] c);
    unique case (c)
      3'h0: pft_retry_ms = 17'h0;
      3'h1: pft_retry_ms = 17'd500;
      3'h2: pft_retry_ms = 17'd1000;
      3'h3: pft_retry_ms = 17'd2000;
      3'h4: pft_retry_ms = 17'd3000;
      3'h5: pft_retry_ms = 17'd4000;
      3'h6: pft_retry_ms = 17'd6000;
      3'h7: pft_retry_ms = 17'd8000;
    endcase
  endfunction

  function automatic logic [16:0] pft_wdog_ms(input logic [3:0] c);
    unique case (c)
      4'h0: pft_wdog_ms = 17'd5;
      4'h1: pft_wdog_ms = 17'd10;
      4'h2: pft_wdog_ms = 17'd20;
      4'h3: pft_wdog_ms = 17'd50;
      4'h4: pft_wdog_ms = 17'd100;
      4'h5: pft_wdog_ms = 17'd200;
      4'h6: pft_wdog_ms = 17'd500;
      4'h7: pft_wdog_ms = 17'd1000;
      4'h8: pft_wdog_ms = 17'd2000;
      4'h9: pft_wdog_ms = 17'd3000;
      4'ha: pft_wdog_ms = 17'd4000;
      4'hb: pft_wdog_ms = 17'd5000;
      4'hc: pft_wdog_ms = 17'd6000;
      4'hd: pft_wdog_ms = 17'd8000;
      4'he: pft_wdog_ms = 17'd10000;
      4'hf: pft_wdog_ms = 17'd15000;
    endcase
  endfunction
endpackage

/* logic/pft_timers.sv */
// Protection fault timers with an AXI4-Lite register port.
`timescale 1ns/1ps
module pft_timers #(
  parameter int MS_CYCLES     = pft_pkg::MS_NS / pft_pkg::CLK_NS,
  parameter int ADC_IV_CYCLES = pft_pkg::T_ADC_IV_NS / pft_pkg::CLK_NS,
  parameter int HOLD_CYCLES   = (pft_pkg::T_HOLD_NS + pft_pkg::CLK_NS - 1) / pft_pkg::CLK_NS
)(
  input  logic        mclk,
  input  logic        arst_n,
  input  logic        ce,
  input  logic [7:0]  s_axi_awaddr,
  input  logic        s_axi_awvalid,
  output logic        s_axi_awready,
  input  logic [31:0] s_axi_wdata,
  input  logic [3:0]  s_axi_wstrb,
  input  logic        s_axi_wvalid,
  output logic        s_axi_wready,
  output logic [1:0]  s_axi_bresp,
  output logic        s_axi_bvalid,
  input  logic        s_axi_bready,
  input  logic [7:0]  s_axi_araddr,
  input  logic        s_axi_arvalid,
  output logic        s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0]  s_axi_rresp,
  output logic        s_axi_rvalid,
  input  logic        s_axi_rready,
  input  logic        input_low_in,
  input  logic        input_high_in,
  input  logic        fast_input_high_in,
  input  logic        output_low_in,
  input  logic        power_ok_in,
  input  logic        gate_low_in,
  input  logic        retry_ok_in,
  output logic        power_good,
  output logic        adc_iv_start,
  output logic        adc_temp_start,
  output logic        gate_step1_off,
  output logic        gate_off,
  output logic        fast_pull_down,
  output logic        fault_o,
  output logic        fault_oe,
  output logic        irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [1:0]              rst_sync_ff;
  logic                    rst_n;
  logic [6:0]              pin1_ff;
  logic [6:0]              pin_ff;

  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  // Pins pass two flops before any use.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin1_ff <= 7'h0;
      pin_ff  <= 7'h0;
    end
    else if (ce)
    begin
      pin1_ff <= {retry_ok_in, gate_low_in, power_ok_in, output_low_in,
                  fast_input_high_in, input_high_in, input_low_in};
      pin_ff  <= pin1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0]             ctrl_ff;
  logic [31:0]             cfg_ff;
  logic [pft_pkg::NEV-1:0] irq_stat_ff;
  logic [pft_pkg::NEV-1:0] irq_mask_ff;
  logic [pft_pkg::NEV-1:0] ev;
  logic                    aw_hold_ff;
  logic                    w_hold_ff;
  logic [7:0]              awaddr_ff;
  logic [31:0]             wdata_ff;
  logic [3:0]              wstrb_ff;
  logic                    bvalid_ff;
  logic [1:0]              bresp_ff;
  logic                    rvalid_ff;
  logic [1:0]              rresp_ff;
  logic [31:0]             rdata_ff;
  logic                    wr_go;
  logic                    kick;
  logic [31:0]             status;
  logic [31:0]             wmask;

  function automatic logic map_ok(input logic [7:0] a);
    map_ok = a == pft_pkg::A_CTRL || a == pft_pkg::A_CFG || a == pft_pkg::A_STAT ||
             a == pft_pkg::A_IRQ || a == pft_pkg::A_MASK || a == pft_pkg::A_KICK;
  endfunction

  assign s_axi_awready = ~aw_hold_ff & ~bvalid_ff;
  assign s_axi_wready  = ~w_hold_ff & ~bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = ~rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rresp   = rresp_ff;
  assign s_axi_rdata   = rdata_ff;
  assign wr_go = aw_hold_ff & w_hold_ff & ~bvalid_ff;
  assign kick  = wr_go && awaddr_ff == pft_pkg::A_KICK;
  assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

  // Address and data may come in either order.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_ff <= 1'b0;
      w_hold_ff  <= 1'b0;
      awaddr_ff  <= 8'h0;
      wdata_ff   <= 32'h0;
      wstrb_ff   <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= 2'h0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_ff <= 1'b1;
        awaddr_ff  <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_ff <= 1'b1;
        wdata_ff  <= s_axi_wdata;
        wstrb_ff  <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold_ff <= 1'b0;
        w_hold_ff  <= 1'b0;
        bvalid_ff  <= 1'b1;
        bresp_ff   <= map_ok(awaddr_ff) ? 2'h0 : 2'h2;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff     <= pft_pkg::CTRL_RST;
      cfg_ff      <= pft_pkg::CFG_RST;
      irq_mask_ff <= '0;
    end
    else if (ce && wr_go)
    begin
      if (awaddr_ff == pft_pkg::A_CTRL)
        ctrl_ff <= (ctrl_ff & ~wmask) | (wdata_ff & wmask);
      if (awaddr_ff == pft_pkg::A_CFG)
        cfg_ff <= (cfg_ff & ~wmask) | (wdata_ff & wmask);
      if (awaddr_ff == pft_pkg::A_MASK)
        irq_mask_ff <= (irq_mask_ff & ~wmask[pft_pkg::NEV-1:0]) | (wdata_ff[pft_pkg::NEV-1:0] & wmask[pft_pkg::NEV-1:0]);
    end
  end

  // A new event wins over a same-cycle clear.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      irq_stat_ff <= '0;
    else if (ce)
    begin
      if (wr_go && awaddr_ff == pft_pkg::A_IRQ)
        irq_stat_ff <= (irq_stat_ff & ~(wdata_ff[pft_pkg::NEV-1:0] & wmask[pft_pkg::NEV-1:0])) | ev;
      else
        irq_stat_ff <= irq_stat_ff | ev;
    end
  end
  assign irq = |(irq_stat_ff & irq_mask_ff);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_ff <= 1'b0;
      rresp_ff  <= 2'h0;
      rdata_ff  <= 32'h0;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid_ff <= 1'b1;
        rresp_ff  <= map_ok({s_axi_araddr[7:2], 2'h0}) ? 2'h0 : 2'h2;
        unique case ({s_axi_araddr[7:2], 2'h0})
          pft_pkg::A_CTRL: rdata_ff <= ctrl_ff;
          pft_pkg::A_CFG:  rdata_ff <= cfg_ff;
          pft_pkg::A_STAT: rdata_ff <= status;
          pft_pkg::A_IRQ:  rdata_ff <= 32'(irq_stat_ff);
          pft_pkg::A_MASK: rdata_ff <= 32'(irq_mask_ff);
          default:         rdata_ff <= 32'h0;
        endcase
      end
      else if (rvalid_ff && s_axi_rready)
        rvalid_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]              us_cnt_ff;
  logic [19:0]             ms_cnt_ff;
  logic                    us_tick;
  logic                    ms_tick;
  logic [15:0]             iv_cnt_ff;
  logic [7:0]              temp_cnt_ff;
  logic                    iv_start_ff;
  logic                    temp_start_ff;

  assign us_tick = us_cnt_ff == 8'(pft_pkg::US_CYCLES - 1);
  assign ms_tick = ms_cnt_ff == 20'(MS_CYCLES - 1);

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      us_cnt_ff <= 8'h0;
      ms_cnt_ff <= 20'h0;
    end
    else if (ce)
    begin
      us_cnt_ff <= us_tick ? 8'h0 : us_cnt_ff + 8'h1;
      ms_cnt_ff <= ms_tick ? 20'h0 : ms_cnt_ff + 20'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      iv_cnt_ff     <= 16'h0;
      temp_cnt_ff   <= 8'h0;
      iv_start_ff   <= 1'b0;
      temp_start_ff <= 1'b0;
    end
    else if (ce)
    begin
      iv_start_ff <= iv_cnt_ff == 16'(ADC_IV_CYCLES - 1); // [RULE3]
      iv_cnt_ff   <= iv_cnt_ff == 16'(ADC_IV_CYCLES - 1) ? 16'h0 : iv_cnt_ff + 16'h1;
      temp_start_ff <= ms_tick && temp_cnt_ff == 8'(pft_pkg::T_TEMP_MS - 1); // [RULE4]
      if (ms_tick)
        temp_cnt_ff <= temp_cnt_ff == 8'(pft_pkg::T_TEMP_MS - 1) ? 8'h0 : temp_cnt_ff + 8'h1;
    end
  end
  assign adc_iv_start   = iv_start_ff;
  assign adc_temp_start = temp_start_ff;

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0]              pg_cnt_ff;
  logic                    pg_ff;
  logic [3:0]              pg_sel;

  // The output follows the pin once it has differed for the selected time.
  assign pg_sel = pin_ff[pft_pkg::P_PG] ? ctrl_ff[pft_pkg::F_RISE +: 4] : ctrl_ff[pft_pkg::F_FALL +: 4];

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pg_cnt_ff <= 4'h0;
      pg_ff     <= 1'b0;
    end
    else if (ce)
    begin
      if (pin_ff[pft_pkg::P_PG] == pg_ff)
        pg_cnt_ff <= 4'h0;
      else if (pg_cnt_ff >= pg_sel) // [RULE1] [RULE2]
      begin
        pg_ff     <= pin_ff[pft_pkg::P_PG];
        pg_cnt_ff <= 4'h0;
      end
      else if (ms_tick)
        pg_cnt_ff <= pg_cnt_ff + 4'h1;
    end
  end
  assign power_good = pg_ff;

  ////////////////////////////////////////////////////////////////////////////
  logic [16:0]             q_cnt_ff [4];
  logic [3:0]              q_ff;
  logic [16:0]             q_tgt [4];
  logic [3:0]              q_tick;
  logic [3:0]              q_ev;

  always_comb
  begin
    q_tgt[pft_pkg::P_UV]   = pft_pkg::pft_fault_ms(ctrl_ff[pft_pkg::F_UV +: 3]); // [RULE12]
    q_tgt[pft_pkg::P_OV]   = pft_pkg::pft_fault_ms(ctrl_ff[pft_pkg::F_OV +: 3]); // [RULE13]
    q_tgt[pft_pkg::P_OVIN] = pft_pkg::pft_ovin_us(ctrl_ff[pft_pkg::F_OVIN +: 3]); // [RULE14]
    q_tgt[pft_pkg::P_OUV]  = pft_pkg::pft_fault_ms(ctrl_ff[pft_pkg::F_OUV +: 3]); // [RULE15]
    q_tick = {ms_tick, us_tick, ms_tick, ms_tick};
    for (int i = 0; i < 4; i++)
      q_ev[i] = pin_ff[i] & ~q_ff[i] & (q_cnt_ff[i] >= q_tgt[i]);
  end

  // Each fault condition must hold for its delay; a drop restarts the count.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q_ff <= 4'h0;
      for (int i = 0; i < 4; i++)
        q_cnt_ff[i] <= 17'h0;
    end
    else if (ce)
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (!pin_ff[i])
        begin
          q_ff[i]     <= 1'b0;
          q_cnt_ff[i] <= 17'h0;
        end
        else if (q_ev[i])
          q_ff[i] <= 1'b1;
        else if (q_tick[i] && !q_ff[i])
          q_cnt_ff[i] <= q_cnt_ff[i] + 17'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  pft_pkg::pft_state_t     state_ff;
  logic [16:0]             tmr_ff;
  logic [16:0]             wd_cnt_ff;
  logic                    wd_exp;
  logic                    trig;
  logic                    disch_done_ff;
  logic                    vgs_seen_ff;
  logic                    sgd_ev;
  logic [12:0]             pd_cnt_ff;
  logic [12:0]             step_cyc;
  logic                    step1_ff;
  logic                    gate_off_ff;
  logic                    fast_ff;
  logic [15:0]             hold_cnt_ff;
  logic                    fault_ff;

  assign wd_exp = state_ff == pft_pkg::ST_RUN && cfg_ff[pft_pkg::F_WEN] &&
                  wd_cnt_ff >= pft_pkg::pft_wdog_ms(cfg_ff[pft_pkg::F_WSEL +: 4]); // [RULE16]
  assign trig   = |q_ev | wd_exp; // [RULE7]
  assign sgd_ev = state_ff == pft_pkg::ST_FAULT && !disch_done_ff && ms_tick &&
                  tmr_ff == 17'(pft_pkg::T_DISCH_MS - 1) && !vgs_seen_ff; // [RULE5]
  assign ev     = {sgd_ev, wd_exp, q_ev};
  // Rounded up so the first step never ends early.
  assign step_cyc = 13'((17'(cfg_ff[pft_pkg::F_STEP +: 10]) * 17'(pft_pkg::STEP_NS) +
                         17'(pft_pkg::CLK_NS - 1)) / 17'(pft_pkg::CLK_NS)); // [RULE11]

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      wd_cnt_ff <= 17'h0;
    else if (ce)
    begin
      if (kick || wd_exp || state_ff != pft_pkg::ST_RUN || !cfg_ff[pft_pkg::F_WEN])
        wd_cnt_ff <= 17'h0;
      else if (ms_tick)
        wd_cnt_ff <= wd_cnt_ff + 17'h1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_ff      <= pft_pkg::ST_RUN;
      tmr_ff        <= 17'h0;
      disch_done_ff <= 1'b0;
      vgs_seen_ff   <= 1'b0;
    end
    else if (ce)
    begin
      unique case (state_ff)
        pft_pkg::ST_RUN:
          if (trig)
          begin
            state_ff      <= pft_pkg::ST_FAULT;
            tmr_ff        <= 17'h0;
            disch_done_ff <= 1'b0;
            vgs_seen_ff   <= 1'b0;
          end
        pft_pkg::ST_FAULT:
        begin
          if (pin_ff[pft_pkg::P_VGS])
            vgs_seen_ff <= 1'b1;
          if (!disch_done_ff && ms_tick)
          begin
            tmr_ff <= tmr_ff + 17'h1;
            if (tmr_ff == 17'(pft_pkg::T_DISCH_MS - 1)) // [RULE5]
              disch_done_ff <= 1'b1;
          end
          if (disch_done_ff && q_ff == 4'h0 && cfg_ff[pft_pkg::F_REN])
          begin
            state_ff <= pft_pkg::ST_COOL;
            tmr_ff   <= 17'h0;
          end
        end
        pft_pkg::ST_COOL:
          if (|q_ev)
            state_ff <= pft_pkg::ST_RUN;
          else if (tmr_ff >= pft_pkg::pft_cool_ms(ctrl_ff[pft_pkg::F_COOL +: 3])) // [RULE9] [RULE17]
          begin
            state_ff <= pft_pkg::ST_RETRY;
            tmr_ff   <= 17'h0;
          end
          else if (ms_tick)
            tmr_ff <= tmr_ff + 17'h1;
        pft_pkg::ST_RETRY:
          if (|q_ev)
            state_ff <= pft_pkg::ST_RUN;
          else if (!pin_ff[pft_pkg::P_ROK])
            tmr_ff <= 17'h0;
          else if (tmr_ff >= pft_pkg::pft_retry_ms(ctrl_ff[pft_pkg::F_RTRY +: 3])) // [RULE10]
            state_ff <= pft_pkg::ST_RUN;
          else if (ms_tick)
            tmr_ff <= tmr_ff + 17'h1;
      endcase
    end
  end

  // A fault in cool-down or retry returns the state to run;
  // its event has already set q_ff, so no trigger is left to reopen fault.
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pd_cnt_ff   <= 13'h0;
      step1_ff    <= 1'b0;
      gate_off_ff <= 1'b0;
      fast_ff     <= 1'b0;
    end
    else if (ce)
    begin
      if (state_ff == pft_pkg::ST_RUN && trig)
      begin
        pd_cnt_ff <= 13'h0;
        if (cfg_ff[pft_pkg::F_FAST])
        begin
          fast_ff     <= 1'b1; // [RULE6]
          gate_off_ff <= 1'b1; // [RULE7]
        end
        else
          step1_ff <= 1'b1; // [RULE7] [RULE11]
      end
      else if (state_ff == pft_pkg::ST_RUN)
      begin
        step1_ff    <= 1'b0;
        gate_off_ff <= 1'b0;
        fast_ff     <= 1'b0;
      end
      else if (fast_ff)
      begin
        pd_cnt_ff <= pd_cnt_ff + 13'h1;
        if (pd_cnt_ff == 13'(pft_pkg::FAST_CYCLES - 1)) // [RULE6]
          fast_ff <= 1'b0;
      end
      else if (step1_ff)
      begin
        pd_cnt_ff <= pd_cnt_ff + 13'h1;
        if (pd_cnt_ff + 13'h1 >= step_cyc) // [RULE11]
        begin
          step1_ff    <= 1'b0;
          gate_off_ff <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hold_cnt_ff <= 16'h0;
      fault_ff    <= 1'b0;
    end
    else if (ce)
    begin
      if (state_ff == pft_pkg::ST_RUN && trig)
        hold_cnt_ff <= 16'(HOLD_CYCLES); // [RULE8]
      else if (hold_cnt_ff != 16'h0)
        hold_cnt_ff <= hold_cnt_ff - 16'h1;
      fault_ff <= (state_ff != pft_pkg::ST_RUN) || (hold_cnt_ff > 16'h1); // [RULE8]
    end
  end

  assign gate_step1_off = step1_ff;
  assign gate_off       = gate_off_ff;
  assign fast_pull_down = fast_ff;
  assign fault_o        = 1'b0;
  assign fault_oe       = fault_ff;
  assign status = {16'h0, 4'(q_ff), 2'h0, 2'(state_ff), 3'h0, fault_ff, fast_ff, gate_off_ff, step1_ff, pg_ff};

endmodule

/* tb/pft_timers_props.sv */
// Fault timer output assertions.
`timescale 1ns/1ps
module pft_timers_props #(
  parameter int MS_CYCLES = 50,
  parameter int ADC_IV_CYCLES = 64,
  parameter int HOLD_CYCLES = 20
)(
  input logic mclk,
  input logic arst_n,
  input logic adc_iv_start,
  input logic adc_temp_start,
  input logic fault_oe,
  input logic gate_step1_off,
  input logic gate_off,
  input logic fast_pull_down,
  input logic power_good,
  input logic power_ok_in,
  input logic s_axi_rvalid,
  input logic s_axi_rready
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  int hold_ff, fast_ff, temp_ff;
  always_ff @(posedge mclk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_ff <= 0;
      fast_ff <= 0;
      temp_ff <= -99999;
    end
    else
    begin
      hold_ff <= fault_oe ? hold_ff + 1 : 0;
      fast_ff <= fast_pull_down ? fast_ff + 1 : 0;
      temp_ff <= adc_temp_start ? 0 : temp_ff + 1;
    end
  end
  property p_iv; adc_iv_start |-> ##ADC_IV_CYCLES adc_iv_start; endproperty
  a_iv: assert property (p_iv) else $error("iv period");
  property p_temp; adc_temp_start && temp_ff >= 0 |-> temp_ff == 200 * MS_CYCLES - 1; endproperty
  a_temp: assert property (p_temp) else $error("temp period");
  property p_hold; $fell(fault_oe) |-> hold_ff >= HOLD_CYCLES; endproperty
  a_hold: assert property (p_hold) else $error("pin hold");
  property p_react; $rose(fault_oe) |-> $past(gate_step1_off) || $past(gate_off); endproperty
  a_react: assert property (p_react) else $error("turn-off late");
  property p_fast; $fell(fast_pull_down) |-> fast_ff == pft_pkg::FAST_CYCLES; endproperty
  a_fast: assert property (p_fast) else $error("pulse width");
  property p_fastoff; $rose(fast_pull_down) |-> gate_off; endproperty
  a_fastoff: assert property (p_fastoff) else $error("no turn-off");
  property p_pg; $changed(power_good) |-> power_good == $past(power_ok_in, 3); endproperty
  a_pg: assert property (p_pg) else $error("power good");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("rvalid stuck");
  c_fault: cover property ($rose(fault_oe));
  c_fast: cover property ($fell(fast_pull_down));
  c_pg: cover property ($rose(power_good));
endmodule

/* tb/pft_gate_model.sv */
// Gate driver model: gate falls after turn-off unless stuck.
`timescale 1ns/1ps
module pft_gate_model (
  input  logic mclk,
  input  logic gate_off,
  input  logic stuck,
  output logic gate_low = 1'h0
);
  logic [3:0] dly_ff = 4'h0;
  always_ff @(posedge mclk)
  begin
    dly_ff <= gate_off ? dly_ff + {3'h0, dly_ff != 4'hf} : 4'h0;
    gate_low <= gate_off && !stuck && dly_ff > 4'h7;
  end
endmodule

/* tb/tb_protection_fault_timers.sv */
// Self-checking fault timer bench.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin failures++; $display("ERROR %s exp %0h got %0h", nm, e, s); end end
module tb_protection_fault_timers;
  localparam int MS = 20;
  logic mclk = 1'h0, arst_n = 1'h0, av = 1'h0, wv = 1'h0, br = 1'h0, arv = 1'h0, rr = 1'h0;
  logic ulow = 1'h0, ohi = 1'h0, pok = 1'h0, stuck = 1'h0, ce = 1'h1, rok = 1'h1, glow, awr, wrd, bv, ard, rv;
  logic power_good, adc_iv_start, adc_temp_start, gate_step1_off, gate_off, fast_pull_down, fault_o, fault_oe, irq;
  logic [7:0] aa = 8'h0, ra = 8'h0;
  logic [31:0] wd = 32'h0, rdata, seed = 32'h3a04;
  logic [1:0] rresp;
  logic [33:0] xe, expq[$];
  int failures = 0, n_checks = 0, n;
  wire fault_n = fault_oe ? fault_o : 1'h1;
  always #2 mclk = ~mclk;
  pft_timers #(.MS_CYCLES(MS), .ADC_IV_CYCLES(64), .HOLD_CYCLES(20)) dut_u (.mclk, .arst_n, .ce,
    .s_axi_awaddr(aa), .s_axi_awvalid(av), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(), .s_axi_bvalid(bv), .s_axi_bready(br),
    .s_axi_araddr(ra), .s_axi_arvalid(arv), .s_axi_arready(ard), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rr), .input_low_in(ulow), .input_high_in(ohi), .fast_input_high_in(1'h0),
    .output_low_in(1'h0), .power_ok_in(pok), .gate_low_in(glow), .retry_ok_in(rok), .power_good,
    .adc_iv_start, .adc_temp_start, .gate_step1_off, .gate_off, .fast_pull_down, .fault_o, .fault_oe, .irq);
  pft_gate_model gm_u (.mclk, .gate_off, .stuck, .gate_low(glow));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic stop_test(input logic bad);
    if (bad) failures++;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    aa <= a;
    wd <= d;
    av <= 1'h1;
    wv <= 1'h1;
    br <= 1'h1;
    for (k = 0; k < 99; k++)
    begin
      @(posedge mclk);
      if (awr) av <= 1'h0;
      if (wrd) wv <= 1'h0;
      if (bv) break;
    end
    br <= 1'h0;
    if (k == 99) stop_test(1'h1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    int k;
    @(posedge mclk);
    expq.push_back(e);
    ra <= a;
    arv <= 1'h1;
    rr <= 1'h1;
    for (k = 0; k < 99; k++)
    begin
      @(posedge mclk);
      if (ard) arv <= 1'h0;
      if (rv) break;
    end
    rr <= 1'h0;
    if (k == 99) stop_test(1'h1);
  endtask
  task automatic wt(ref logic s, input logic v, output int c);
    for (c = 0; c < 30000 && s !== v; c++)
      @(posedge mclk);
    if (c == 30000) stop_test(1'h1);
  endtask
  always @(posedge mclk)
  begin
    if (rv && rr)
    begin
      xe = expq.pop_front();
      `CHK("rdata", xe, {rresp, rdata})
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (4) @(posedge mclk);
    arst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    rd(8'h18, {2'h2, 32'h0});
    repeat (3)
    begin
      seed = lfsr(seed);
      wr(pft_pkg::A_CTRL, seed);
      rd(pft_pkg::A_CTRL, {2'h0, seed});
    end
    wt(adc_iv_start, 1'h1, n);
    wt(adc_iv_start, 1'h0, n);
    wt(adc_iv_start, 1'h1, n);
    `CHK("iv_gap", 63, n)
    wr(pft_pkg::A_CTRL, 32'h0000_0603);
    wr(pft_pkg::A_CFG, 32'h0000_0004);
    wr(pft_pkg::A_MASK, 32'h0000_0021);
    pok <= 1'h1;
    wt(power_good, 1'h1, n);
    `CHK("pg_rise", 1'h1, n >= 2 * MS && n <= 3 * MS + 6)
    ulow <= 1'h1;
    wt(gate_step1_off, 1'h1, n);
    `CHK("uv_delay", 1'h1, n >= 999 * MS && n <= 1000 * MS + 6)
    wt(gate_off, 1'h1, n);
    `CHK("step1", 25, n)
    `CHK("uv_irq", 1'h1, irq)
    `CHK("pin", 1'h0, fault_n)
    repeat (300) @(posedge mclk);
    rd(pft_pkg::A_IRQ, 34'h1);
    wr(pft_pkg::A_IRQ, 32'h1);
    `CHK("irq_clr", 1'h0, irq)
    arst_n <= 1'h0;
    ulow <= 1'h0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'h1;
    repeat (3) @(posedge mclk);
    wr(pft_pkg::A_CTRL, 32'h0100_0000);
    wr(pft_pkg::A_CFG, 32'h0000_3000);
    wr(pft_pkg::A_MASK, 32'h0000_0020);
    stuck <= 1'h1;
    ohi <= 1'h1;
    wt(fast_pull_down, 1'h1, n);
    `CHK("fast_react", 1'h1, n <= 6)
    wt(fast_pull_down, 1'h0, n);
    `CHK("fast_len", pft_pkg::FAST_CYCLES, n)
    `CHK("sgd_irq", 1'h1, irq)
    rd(pft_pkg::A_IRQ, 34'h22);
    stuck <= 1'h0;
    ohi <= 1'h0;
    wt(fault_oe, 1'h0, n);
    `CHK("cool", 1'h1, n >= 999 * MS && n <= 1000 * MS + 60)
    stop_test(1'h0);
  end
endmodule
bind pft_timers pft_timers_props #(.MS_CYCLES(MS_CYCLES), .ADC_IV_CYCLES(ADC_IV_CYCLES), .HOLD_CYCLES(HOLD_CYCLES))
  u_props (.mclk, .arst_n, .adc_iv_start, .adc_temp_start, .fault_oe, .gate_step1_off, .gate_off,
  .fast_pull_down, .power_good, .power_ok_in, .s_axi_rvalid, .s_axi_rready);
